//--- hw/load_control_frame_builder.sv
// Purpose: Checks host command frames and decodes the load control event they carry;
//          holds the 64-bit destination address settings.
// Assumes: Host bytes arrive from logic on i_clk; settings written by the host-side parser.
// Notes: Decoded fields update only on a frame that passes checksum and length checks.
`timescale 1ns/1ps
`default_nettype none
`include "lcf_regs.svh"

module load_control_frame_builder (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Host byte stream
   input wire logic i_rx_valid,
   input wire logic [7:0] i_rx_byte,
   // Destination address settings
   input wire logic i_cfg_wr,
   input wire logic i_cfg_upper,
   input wire logic [31:0] i_cfg_wdata,
   // Decoded event and frame verdicts
   output lcf_pkg::event_t o_event,
   output logic o_frame_good,
   output logic o_frame_err,
   // Destination address state
   output logic [31:0] o_dest_addr_upper,
   output logic [31:0] o_dest_addr_lower,
   output logic o_dest_broadcast,
   output logic o_dest_coordinator
);

   lcf_pkg::rx_byte_t body;
   logic rx_ok;
   logic rx_bad;
   lcf_pkg::main_regs_t r;
   lcf_pkg::main_regs_t next_r;

   lcf_frame_rx u_rx (
      .i_clk(i_clk),
      .i_nrst(i_nrst),
      .i_valid(i_rx_valid),
      .i_byte(i_rx_byte),
      .o_body(body),
      .o_ok(rx_ok),
      .o_bad(rx_bad)
   );

   // ==========================================================
   // Helpers
   function automatic lcf_pkg::event_t take_byte(lcf_pkg::event_t e, logic [7:0] off,
                                                 logic [7:0] b);
      lcf_pkg::event_t t;
      t = e;
      case (off)
         `LCF_OFF_NET_HI: t.net_addr[15:8] = b;
         `LCF_OFF_NET_LO: t.net_addr[7:0] = b;
         `LCF_OFF_FCTRL: begin
            t.fc.cluster_cmd = (b[`LCF_FC_TYPE_HI:`LCF_FC_TYPE_LO] == `LCF_FC_TYPE_CLUSTER);
            t.fc.vendor = b[`LCF_FC_VENDOR];
            t.fc.to_client = b[`LCF_FC_DIR];
            t.fc.default_rsp = ~b[`LCF_FC_NO_DRSP];
            t.fc.reserved_bad = |b[`LCF_FC_RSVD_HI:`LCF_FC_RSVD_LO];
         end
         `LCF_OFF_EVID0: t.event_id[7:0] = b;
         `LCF_OFF_EVID1: t.event_id[15:8] = b;
         `LCF_OFF_EVID2: t.event_id[23:16] = b;
         `LCF_OFF_EVID3: t.event_id[31:24] = b;
         `LCF_OFF_HEAT_LO: t.heat_sp[7:0] = b;
         `LCF_OFF_HEAT_HI: t.heat_sp[15:8] = b;
         `LCF_OFF_LOAD: t.load_limit = b;
         `LCF_OFF_DUTY: t.duty = b;
         `LCF_OFF_EVCTRL: t.event_ctrl = b;
         default: t = e;
      endcase
      t.heat_used = (t.heat_sp != `LCF_HEAT_UNUSED);
      t.load_used = (t.load_limit != `LCF_LOAD_UNUSED);
      t.duty_used = (t.duty != `LCF_DUTY_UNUSED);
      return t;
   endfunction : take_byte

   function automatic logic is_bcast(logic [31:0] hi, logic [31:0] lo);
      return {hi, lo} == `LCF_DEST_BCAST;
   endfunction : is_bcast

   function automatic logic is_coord(logic [31:0] hi, logic [31:0] lo);
      return {hi, lo} == `LCF_DEST_COORD;
   endfunction : is_coord

   // ==========================================================
   // Next state
   always_comb begin
      next_r = r;
      next_r.good = 1'b0;
      next_r.err = 1'b0;
      if (body.valid) begin
         next_r.shadow = take_byte(r.shadow, body.offset, body.data);
         next_r.last_off = body.offset;
      end
      // A short frame never reaches the option byte, so its fields stay untrusted
      if (rx_ok && r.last_off >= `LCF_OFF_EVCTRL) begin
         next_r.live = r.shadow;
         next_r.good = 1'b1;
         next_r.last_off = 8'h0;
      end else if (rx_ok || rx_bad) begin
         next_r.err = 1'b1;
         next_r.last_off = 8'h0;
      end
      if (i_cfg_wr) begin
         if (i_cfg_upper) begin
            next_r.hi = i_cfg_wdata;
         end else begin
            next_r.lo = i_cfg_wdata;
         end
      end
      next_r.bcast = is_bcast(next_r.hi, next_r.lo);
      next_r.coord = is_coord(next_r.hi, next_r.lo);
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         r <= '0;
         r.hi <= `LCF_DEST_UPPER_RST;
         r.lo <= `LCF_DEST_LOWER_RST;
         r.coord <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign o_event = r.live;
   assign o_frame_good = r.good;
   assign o_frame_err = r.err;
   assign o_dest_addr_upper = r.hi;
   assign o_dest_addr_lower = r.lo;
   assign o_dest_broadcast = r.bcast;
   assign o_dest_coordinator = r.coord;

   // ==========================================================
   // Checks
   sequence s_fctrl_byte;
      body.valid && body.offset == `LCF_OFF_FCTRL;
   endsequence

   fc_decode_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      s_fctrl_byte |=> r.shadow.fc.cluster_cmd == ($past(body.data[1:0]) == 2'h1)
      && r.shadow.fc.vendor == $past(body.data[2]) && r.shadow.fc.to_client == $past(body.data[3]))
      else $error("frame control decode wrong");

   net_addr_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      body.valid && body.offset == `LCF_OFF_NET_HI ##1 body.valid && body.offset == `LCF_OFF_NET_LO
      |=> r.shadow.net_addr == {$past(body.data, 2), $past(body.data)})
      else $error("network address order wrong");

   event_id_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      body.valid && body.offset == `LCF_OFF_EVID0 |=> r.shadow.event_id[7:0] == $past(body.data))
      else $error("event id low byte misplaced");

   heat_flag_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      o_frame_good |-> o_event.heat_used == (o_event.heat_sp != 16'h8000))
      else $error("heating unused flag wrong");

   load_duty_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      o_frame_good |-> o_event.load_used == (o_event.load_limit != 8'h80)
      && o_event.duty_used == (o_event.duty != 8'hff))
      else $error("load or duty unused flag wrong");

   commit_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      rx_bad |=> !o_frame_good && $stable(o_event))
      else $error("bad frame changed the event");

   upper_write_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_cfg_wr && i_cfg_upper |=> o_dest_addr_upper == $past(i_cfg_wdata))
      else $error("upper address not written");

   lower_write_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      i_cfg_wr && !i_cfg_upper |=> o_dest_addr_lower == $past(i_cfg_wdata))
      else $error("lower address not written");

   dest_special_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      o_dest_broadcast == ({o_dest_addr_upper, o_dest_addr_lower} == 64'hffff)
      && o_dest_coordinator == ({o_dest_addr_upper, o_dest_addr_lower} == 64'h0))
      else $error("broadcast or coordinator flag wrong");

   verdict_excl_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      !(o_frame_good && o_frame_err))
      else $error("frame both accepted and discarded");

   short_frame_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      rx_ok && r.last_off < `LCF_OFF_EVCTRL |=> o_frame_err && $stable(o_event))
      else $error("short frame not discarded");

   commit_good_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      rx_ok && r.last_off >= `LCF_OFF_EVCTRL |=> o_frame_good && o_event == $past(r.shadow))
      else $error("good frame not committed");

   heat_order_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      body.valid && body.offset == `LCF_OFF_HEAT_HI |=> r.shadow.heat_sp[15:8] == $past(body.data))
      else $error("heating set point high byte misplaced");

   event_id_hi_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      body.valid && body.offset == `LCF_OFF_EVID3 |=> r.shadow.event_id[31:24] == $past(body.data))
      else $error("event id high byte misplaced");

   event_ctrl_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      body.valid && body.offset == `LCF_OFF_EVCTRL |=> r.shadow.event_ctrl == $past(body.data))
      else $error("event option byte misplaced");

endmodule : load_control_frame_builder
`default_nettype wire

//--- hw/lcf_regs.svh
// Purpose: Constants for the load control frame builder: offsets, field bits, sentinels, resets.
// Assumes: Frame offsets count from the start delimiter at offset 0.
// Notes: Definitions only.
`ifndef LCF_REGS_SVH
`define LCF_REGS_SVH

// ==========================================================
// Framing
`define LCF_DELIM 8'h7e
`define LCF_CSUM_OK 8'hff
`define LCF_OFF_LEN_HI 8'h01
`define LCF_OFF_LEN_LO 8'h02
`define LCF_OFF_BODY 8'h03

// ==========================================================
// Field offsets
`define LCF_OFF_NET_HI 8'h0d
`define LCF_OFF_NET_LO 8'h0e
`define LCF_OFF_FCTRL 8'h17
`define LCF_OFF_EVID0 8'h1a
`define LCF_OFF_EVID1 8'h1b
`define LCF_OFF_EVID2 8'h1c
`define LCF_OFF_EVID3 8'h1d
`define LCF_OFF_HEAT_LO 8'h2c
`define LCF_OFF_HEAT_HI 8'h2d
`define LCF_OFF_LOAD 8'h2e
`define LCF_OFF_DUTY 8'h2f
`define LCF_OFF_EVCTRL 8'h30

// ==========================================================
// Frame control byte fields
`define LCF_FC_TYPE_LO 0
`define LCF_FC_TYPE_HI 1
`define LCF_FC_TYPE_CLUSTER 2'h1
`define LCF_FC_VENDOR 2
`define LCF_FC_DIR 3
`define LCF_FC_NO_DRSP 4
`define LCF_FC_RSVD_LO 5
`define LCF_FC_RSVD_HI 7

// ==========================================================
// Unused-field sentinels
`define LCF_HEAT_UNUSED 16'h8000
`define LCF_LOAD_UNUSED 8'h80
`define LCF_DUTY_UNUSED 8'hff

// ==========================================================
// Destination address
`define LCF_DEST_UPPER_RST 32'h0
`define LCF_DEST_LOWER_RST 32'h0
`define LCF_DEST_BCAST 64'hffff
`define LCF_DEST_COORD 64'h0

`endif

//--- hw/lcf_pkg.sv
// Purpose: Types shared by the frame receiver and the load control frame builder.
// Assumes: Nothing beyond lcf_regs.svh.
// Notes: Types only.
package lcf_pkg;

   // ==========================================================
   // Receiver
   typedef enum logic [2:0] {RX_IDLE, RX_LEN_HI, RX_LEN_LO, RX_BODY, RX_CSUM} rx_state_t;

   typedef struct packed {
      logic valid;
      logic [7:0] offset;
      logic [7:0] data;
   } rx_byte_t;

   typedef struct packed {
      rx_state_t st;
      logic [15:0] remain;
      logic [7:0] offset;
      logic [7:0] sum;
      rx_byte_t out;
      logic ok;
      logic bad;
   } rx_regs_t;

   // ==========================================================
   // Decoded event and builder registers
   typedef struct packed {
      logic cluster_cmd;
      logic vendor;
      logic to_client;
      logic default_rsp;
      logic reserved_bad;
   } fc_t;

   typedef struct packed {
      logic [15:0] net_addr;
      fc_t fc;
      logic [31:0] event_id;
      logic [15:0] heat_sp;
      logic heat_used;
      logic [7:0] load_limit;
      logic load_used;
      logic [7:0] duty;
      logic duty_used;
      logic [7:0] event_ctrl;
   } event_t;

   typedef struct packed {
      event_t shadow;
      event_t live;
      logic [7:0] last_off;
      logic [31:0] hi;
      logic [31:0] lo;
      logic bcast;
      logic coord;
      logic good;
      logic err;
   } main_regs_t;

endpackage : lcf_pkg

//--- hw/lcf_frame_rx.sv
// Purpose: Byte-serial frame receiver: delimiter, length, body with offsets, checksum.
// Assumes: Bytes come from logic on i_clk, one per i_valid cycle.
// Notes: A delimiter inside a body is treated as data; resync only after the checksum.
`timescale 1ns/1ps
`default_nettype none
`include "lcf_regs.svh"

module lcf_frame_rx (
   // Clock and reset
   input wire logic i_clk,
   input wire logic i_nrst,
   // Byte stream in
   input wire logic i_valid,
   input wire logic [7:0] i_byte,
   // Body bytes and verdict out
   output lcf_pkg::rx_byte_t o_body,
   output logic o_ok,
   output logic o_bad
);

   lcf_pkg::rx_regs_t r;
   lcf_pkg::rx_regs_t next_r;

   // ==========================================================
   // Next state
   always_comb begin
      next_r = r;
      next_r.out.valid = 1'b0;
      next_r.ok = 1'b0;
      next_r.bad = 1'b0;
      if (i_valid) begin
         unique case (r.st)
            lcf_pkg::RX_IDLE: begin
               if (i_byte == `LCF_DELIM) begin
                  next_r.st = lcf_pkg::RX_LEN_HI;
                  next_r.offset = `LCF_OFF_LEN_HI;
               end
            end
            lcf_pkg::RX_LEN_HI: begin
               next_r.remain[15:8] = i_byte;
               next_r.offset = `LCF_OFF_LEN_LO;
               next_r.st = lcf_pkg::RX_LEN_LO;
            end
            lcf_pkg::RX_LEN_LO: begin
               next_r.remain[7:0] = i_byte;
               next_r.offset = `LCF_OFF_BODY;
               next_r.sum = 8'h0;
               next_r.st = ({r.remain[15:8], i_byte} == 16'h0) ?
                  lcf_pkg::RX_CSUM : lcf_pkg::RX_BODY;
            end
            lcf_pkg::RX_BODY: begin
               next_r.out.valid = 1'b1;
               next_r.out.offset = r.offset;
               next_r.out.data = i_byte;
               next_r.sum = 8'(r.sum + i_byte);
               // Offsets saturate; fields past 0xff are never decoded
               next_r.offset = (r.offset == 8'hff) ? r.offset : 8'(r.offset + 8'h1);
               next_r.remain = 16'(r.remain - 16'h1);
               if (r.remain == 16'h1) begin
                  next_r.st = lcf_pkg::RX_CSUM;
               end
            end
            lcf_pkg::RX_CSUM: begin
               next_r.ok = (8'(r.sum + i_byte) == `LCF_CSUM_OK);
               next_r.bad = (8'(r.sum + i_byte) != `LCF_CSUM_OK);
               next_r.st = lcf_pkg::RX_IDLE;
            end
            default: next_r.st = lcf_pkg::RX_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign o_body = r.out;
   assign o_ok = r.ok;
   assign o_bad = r.bad;

   // ==========================================================
   // Checks
   sequence s_delim_seen;
      r.st == lcf_pkg::RX_IDLE && i_valid && i_byte == `LCF_DELIM;
   endsequence
   // The host may leave idle cycles between header bytes
   sequence s_len_hi_seen;
      r.st == lcf_pkg::RX_LEN_HI && i_valid;
   endsequence

   header_order_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      (s_delim_seen |=> r.st == lcf_pkg::RX_LEN_HI)
      and (s_len_hi_seen |=> r.st == lcf_pkg::RX_LEN_LO))
      else $error("length bytes not taken after delimiter");

   checksum_ok_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
      r.st == lcf_pkg::RX_CSUM && i_valid |=>
      (o_ok == (8'($past(r.sum) + $past(i_byte)) == `LCF_CSUM_OK)) && (o_ok != o_bad))
      else $error("checksum verdict wrong");

endmodule : lcf_frame_rx
`default_nettype wire

//--- tb/host_link.sv
// Purpose: Host side of the serial byte link: sends whole command frames.
// Assumes: Bytes change 1 ns after a rising edge; no back pressure exists.
// Notes: The data line never repeats a stale byte while the strobe is low.
`timescale 1ns/1ps
`default_nettype none

module host_link (
   // Clock
   input wire logic i_clk,
   // Byte stream to the device
   output logic o_valid,
   output logic [7:0] o_byte
);
   logic [7:0] last_byte;

   initial begin
      o_valid = 1'b0;
      o_byte = 8'h00;
      last_byte = 8'h00;
   end

   // ==========================================================
   // Byte level
   // Gaps show the inverse byte so a sticky receiver cannot pass by luck
   task automatic put(input logic [7:0] b, input int gap);
      repeat (gap) begin
         @(posedge i_clk) #1;
         o_valid = 1'b0;
         o_byte = ~last_byte;
      end
      @(posedge i_clk) #1;
      o_valid = 1'b1;
      o_byte = b;
      last_byte = b;
   endtask : put

   task automatic quiet();
      @(posedge i_clk) #1;
      o_valid = 1'b0;
      o_byte = ~last_byte;
   endtask : quiet

   // ==========================================================
   // Frame level
   // Set points and reserved bits are laid out by the caller's body
   task automatic send_frame(input logic [7:0] body[$], input logic bad, input int gap);
      logic [7:0] sum;
      logic [15:0] len;
      len = 16'(body.size());
      sum = 8'h00;
      put(8'h7e, gap);
      put(len[15:8], gap);
      put(len[7:0], gap);
      foreach (body[i]) begin
         put(body[i], gap);
         sum = sum + body[i];
      end
      put((8'hff - sum) ^ {7'h00, bad}, gap);
   endtask : send_frame
endmodule : host_link

`default_nettype wire

//--- tb/tb.sv
// Purpose: Self-checking bench for the load control frame builder.
// Assumes: 25 MHz clock; inputs change 1 ns after the rising edge.
// Notes: Row table covers decoding; hand tests cover errors, framing and settings.
`timescale 1ns/1ps
`default_nettype none

module tb;
   typedef struct packed {
      logic [7:0] fc;
      logic [15:0] net;
      logic [31:0] evid;
      logic [15:0] heat;
      logic [7:0] load;
      logic [7:0] duty;
      logic [7:0] ectl;
      logic [4:0] flags;
      logic [2:0] used;
   } row_t;

   logic clk;
   logic nrst;
   logic rx_valid;
   logic [7:0] rx_byte;
   logic cfg_wr;
   logic cfg_upper;
   logic [31:0] cfg_wdata;
   lcf_pkg::event_t ev;
   logic good;
   logic bad;
   logic [31:0] up;
   logic [31:0] lo;
   logic bcast;
   logic coord;
   int err_total;
   int checks_done;
   int cycles;
   int good_cnt;
   logic [7:0] body[$];
   // Row 2 breaks the reserved-bit rule on purpose
   row_t rows[4] = '{
      '{8'h09, 16'h5678, 32'h12345678, 16'h8000, 8'h80, 8'hff, 8'h00, 5'h16, 3'h0},
      '{8'h14, 16'h0001, 32'h7e7e0102, 16'h0898, 8'h32, 8'h40, 8'h03, 5'h08, 3'h7},
      '{8'he3, 16'hffff, 32'hffffffff, 16'h7fff, 8'h81, 8'hfe, 8'hff, 5'h03, 3'h7},
      '{8'h0d, 16'h0000, 32'h00000001, 16'h8001, 8'h7f, 8'hff, 8'h80, 5'h1e, 3'h6}};

   host_link host (.i_clk(clk), .o_valid(rx_valid), .o_byte(rx_byte));

   load_control_frame_builder DUT (
      .i_clk(clk), .i_nrst(nrst), .i_rx_valid(rx_valid), .i_rx_byte(rx_byte),
      .i_cfg_wr(cfg_wr), .i_cfg_upper(cfg_upper), .i_cfg_wdata(cfg_wdata),
      .o_event(ev), .o_frame_good(good), .o_frame_err(bad),
      .o_dest_addr_upper(up), .o_dest_addr_lower(lo),
      .o_dest_broadcast(bcast), .o_dest_coordinator(coord));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (good === 1'b1) begin
         good_cnt++;
      end
      if (cycles == 20000) begin
         err_total++;
         report_and_stop();
      end
   end

   // ==========================================================
   // Helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic report_and_stop();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : report_and_stop

   // Body index is frame offset minus three
   task automatic fill(input row_t r);
      body = {};
      repeat (46) body.push_back(8'h00);
      body[20] = r.fc;
      body[10] = r.net[15:8];
      body[11] = r.net[7:0];
      for (int k = 0; k < 4; k++) body[23 + k] = r.evid[8*k +: 8];
      body[41] = r.heat[7:0];
      body[42] = r.heat[15:8];
      body[43] = r.load;
      body[44] = r.duty;
      body[45] = r.ectl;
   endtask : fill

   task automatic wait_verdict(input logic exp_good);
      int n;
      n = 0;
      host.quiet();
      while (good !== 1'b1 && bad !== 1'b1 && n < 8) begin
         @(posedge clk) #1;
         n++;
      end
      // Verdict register follows the receiver by one edge
      check(32'(n), 32'd1);
      check(32'(good), 32'(exp_good));
      check(32'(bad), 32'(!exp_good));
   endtask : wait_verdict

   task automatic check_event(input row_t r);
      check(32'(ev.net_addr), 32'(r.net));
      check(ev.event_id, r.evid);
      check(32'(ev.heat_sp), 32'(r.heat));
      check(32'(ev.load_limit), 32'(r.load));
      check(32'(ev.duty), 32'(r.duty));
      check(32'(ev.event_ctrl), 32'(r.ectl));
      check(32'(ev.fc), 32'(r.flags));
      check(32'({ev.heat_used, ev.load_used, ev.duty_used}), 32'(r.used));
   endtask : check_event

   task automatic check_reset();
      check(32'(ev), 32'h0);
      check(32'(ev.event_id), 32'h0);
      check(up, 32'h0);
      check(lo, 32'h0);
      check(32'({bcast, coord}), 32'h1);
   endtask : check_reset

   // Write strobe stays high so successive calls write back to back
   task automatic do_cfg(input logic u, input logic [31:0] d, input logic [1:0] fl);
      cfg_wr = 1'b1;
      cfg_upper = u;
      cfg_wdata = d;
      @(posedge clk) #1;
      check(u ? up : lo, d);
      check(32'({bcast, coord}), 32'(fl));
   endtask : do_cfg

   // ==========================================================
   // Main sequence
   initial begin
      nrst = 1'b0;
      cfg_wr = 1'b0;
      cfg_upper = 1'b0;
      cfg_wdata = 32'h0;
      err_total = 0;
      checks_done = 0;
      cycles = 0;
      good_cnt = 0;
      repeat (3) @(posedge clk);
      #1;
      nrst = 1'b1;
      check_reset();
      foreach (rows[i]) begin
         fill(rows[i]);
         host.send_frame(body, 1'b0, i % 2);
         wait_verdict(1'b1);
         check_event(rows[i]);
      end
      fill(rows[0]);
      host.send_frame(body, 1'b1, 0);
      wait_verdict(1'b0);
      check_event(rows[3]);
      body = {};
      host.send_frame(body, 1'b0, 0);
      wait_verdict(1'b0);
      host.put(8'h55, 0);
      host.put(8'h7f, 0);
      fill(rows[1]);
      host.send_frame(body, 1'b0, 0);
      wait_verdict(1'b1);
      check_event(rows[1]);
      // Let the previous good pulse be counted before clearing
      @(posedge clk) #1;
      good_cnt = 0;
      fill(rows[2]);
      host.send_frame(body, 1'b0, 0);
      fill(rows[0]);
      host.send_frame(body, 1'b0, 0);
      wait_verdict(1'b1);
      check_event(rows[0]);
      @(posedge clk) #1;
      check(32'(good_cnt), 32'd2);
      @(posedge clk) #1;
      do_cfg(1'b0, 32'h0000ffff, 2'h2);
      do_cfg(1'b1, 32'h00000001, 2'h0);
      do_cfg(1'b1, 32'h00000000, 2'h2);
      do_cfg(1'b0, 32'h0001ffff, 2'h0);
      do_cfg(1'b0, 32'h00000000, 2'h1);
      do_cfg(1'b1, 32'hffffffff, 2'h0);
      cfg_wr = 1'b0;
      nrst = 1'b0;
      @(posedge clk) #1;
      nrst = 1'b1;
      check_reset();
      report_and_stop();
   end
endmodule : tb

`default_nettype wire
